// ---- pbs_pkg.sv ----
// Purpose: constants and types for the profiling buffer id/status bank
// Assumes: 64-bit system registers, reached by encoded access requests
// Notes: field positions and codes are shared by all design files
package pbs_pkg;
    // ------
    // register access encodings
    // ------
    localparam logic [1:0] ENC_OP0 = 2'h3;
    localparam logic [2:0] ENC_OP1 = 3'h0;
    localparam logic [3:0] ENC_CRN = 4'h9;
    localparam logic [3:0] ENC_CRM = 4'hA;
    localparam logic [2:0] ENC_OP2_ID = 3'h7;
    localparam logic [2:0] ENC_OP2_STATUS = 3'h3;
    localparam logic [5:0] TRAP_CLASS_SYSREG = 6'h18;

    // ------
    // identification register layout
    // ------
    localparam int ID_ALIGN_LSB = 0;
    localparam int ID_PROHIB_BIT = 4;
    localparam int ID_FLAGUPD_BIT = 5;
    localparam logic [3:0] ALIGN_MAX = 4'hB;

    // ------
    // status register layout
    // ------
    localparam int ST_EC_LSB = 26;
    localparam int ST_LOST_BIT = 19;
    localparam int ST_EA_BIT = 18;
    localparam int ST_SVC_BIT = 17;
    localparam int ST_COLLISION_FLAG_BIT = 16;
    localparam int ST_MSS_LSB = 0;
    localparam logic [5:0] EC_OTHER = 6'h00;
    localparam logic [5:0] EC_GPC = 6'h1E;
    localparam logic [5:0] EC_IMPDEF = 6'h1F;
    localparam logic [5:0] EC_S1_ABORT = 6'h24;
    localparam logic [5:0] EC_S2_ABORT = 6'h25;
    localparam logic [5:0] EC_RESET = 6'h00;
    localparam logic [15:0] MSS_RESET = 16'h0000;
    localparam logic [1:0] E2PB_HIGHER = 2'h0;

    // ------
    // exception levels and security states
    // ------
    localparam logic [1:0] EL0 = 2'h0;
    localparam logic [1:0] EL1 = 2'h1;
    localparam logic [1:0] EL2 = 2'h2;
    localparam logic [1:0] EL3 = 2'h3;
    typedef enum logic [1:0] {
        SEC_SECURE,
        SEC_NONSECURE,
        SEC_REALM,
        SEC_ROOT
    } pbs_sec_t;
endpackage

// ---- pbs_ctx_if.sv ----
// Purpose: carries the privilege context to the ownership checker
// Assumes: all signals on the core clock
// Notes: src drives context, chk answers with the prohibited flag
`timescale 1ns/100ps
`default_nettype none
interface pbs_ctx_if;
    logic [1:0] el;
    pbs_pkg::pbs_sec_t sec;
    logic have_el3;
    logic have_el2;
    logic sel2_impl;
    logic sel2_en;
    logic realm_extension_present;
    logic [1:0] top_level_buffer_owner_ctrl;
    logic top_level_owner_extension;
    logic [1:0] level2_buffer_owner_ctrl;
    logic prohibited;
    modport src (
        output el, sec, have_el3, have_el2, sel2_impl, sel2_en,
        output realm_extension_present, top_level_buffer_owner_ctrl,
        output top_level_owner_extension, level2_buffer_owner_ctrl,
        input prohibited
    );
    modport chk (
        input el, sec, have_el3, have_el2, sel2_impl, sel2_en,
        input realm_extension_present, top_level_buffer_owner_ctrl,
        input top_level_owner_extension, level2_buffer_owner_ctrl,
        output prohibited
    );
endinterface
`default_nettype wire

// ---- pbs_own_chk.sv ----
// Purpose: decides whether buffer programming is prohibited here
// Assumes: context is stable in the cycle it is read
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module pbs_own_chk (
    // context and answer
    pbs_ctx_if.chk ctx
);
    logic el12;
    logic e2pb_hi;
    logic own_ns;
    logic own_rl;
    logic is_s;
    logic is_ns;
    logic is_rl;

    // ------
    // decode of owner and current state
    // ------
    // owner: extension bit selects realm, else high bit of ctrl
    assign own_rl = ctx.realm_extension_present &
                    ctx.top_level_owner_extension;
    assign own_ns = !own_rl & ctx.top_level_buffer_owner_ctrl[1];
    assign el12 = (ctx.el == pbs_pkg::EL1) || (ctx.el == pbs_pkg::EL2);
    assign e2pb_hi = (ctx.level2_buffer_owner_ctrl ==
                      pbs_pkg::E2PB_HIGHER);
    assign is_s = (ctx.sec == pbs_pkg::SEC_SECURE);
    assign is_ns = (ctx.sec == pbs_pkg::SEC_NONSECURE);
    assign is_rl = (ctx.sec == pbs_pkg::SEC_REALM);

    // ------
    // prohibited flag per owner
    // ------
    always_comb begin
        ctx.prohibited = 1'b0;
        if (ctx.el == pbs_pkg::EL3) begin
            ctx.prohibited = 1'b0;
        end else if (ctx.have_el3 && own_rl) begin
            ctx.prohibited = ((is_ns || is_s) && el12) ||
                (is_rl && ctx.el == pbs_pkg::EL1 && e2pb_hi);
        end else if (ctx.have_el3 && own_ns) begin
            ctx.prohibited = (is_s && ctx.el == pbs_pkg::EL1) ||
                (is_s && ctx.el == pbs_pkg::EL2 && ctx.sel2_impl) ||
                (is_ns && ctx.el == pbs_pkg::EL1 && ctx.have_el2 &&
                 e2pb_hi) ||
                (ctx.realm_extension_present && is_rl && el12);
        end else if (ctx.have_el3) begin
            ctx.prohibited = (is_ns && el12) ||
                (ctx.realm_extension_present && is_rl && el12) ||
                (is_s && ctx.el == pbs_pkg::EL1 && ctx.sel2_impl &&
                 ctx.sel2_en && e2pb_hi);
        end else if (ctx.have_el2 && e2pb_hi) begin
            ctx.prohibited = (ctx.el == pbs_pkg::EL1);
        end
    end
endmodule
`default_nettype wire

// ---- pbs_regs.sv ----
// What this block does
// - id prohibited flag reads 1 when programming not allowed, else 0.
// - secure owner: flag set for NS EL1/2, realm EL1/2, gated secure EL1.
// - non-secure owner: flag set for secure EL1/2, gated NS EL1, realm.
// - realm owner: flag set for NS and secure EL1/2, gated realm EL1.
// - no top level: EL1 prohibited when EL2 is present and ownership field is 00; else 0.
// - four-bit alignment field reports power-of-two pointer alignment.
// - nonzero alignment pads every written record to whole multiples.
// - id read undefined at EL0, trapped at EL1 by read trap, else returned.
// - status register holds syndrome of why buffer was stopped.
// - six-bit event class encodes cause; other codes reserved.
// - writing reserved event class leaves field value unknown.
// - warm reset leaves status fields unknown; no value relied upon. Here srst_i loads zero into every status field.
// - record-lost bit shows whether last record was complete.
// - asynchronous external abort event sets record-lost bit.
// - external abort bit set when abort detected, else reads zero.
// - service bit mirrors the buffer interrupt.
// - collision bit set once any collision recorded.
// - sixteen-bit syndrome carries event detail incl. fault status code.
// - prohibited flag is bit 4 and reads zero at top level.
//
// Purpose: id and status/syndrome system registers of a profiling buffer
// Assumes: one access request per cycle, answered on the next edge
// Notes: warm reset is srst_i; status fields take zero at reset
`timescale 1ns/100ps
`default_nettype none
module pbs_regs #(
    parameter logic [3:0] ALIGN_CODE = 4'h0,
    parameter bit FLAG_UPDATES = 1'b0,
    parameter bit SETS_ASYNC_LOST = 1'b1,
    parameter bit SETS_EXT_ABORT = 1'b1,
    parameter int LEN_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register access request
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [1:0] req_op0_i,
    input wire logic [2:0] req_op1_i,
    input wire logic [3:0] req_crn_i,
    input wire logic [3:0] req_crm_i,
    input wire logic [2:0] req_op2_i,
    input wire logic [63:0] req_wdata_i,
    // access answer
    output logic resp_valid_o,
    output logic [63:0] resp_rdata_o,
    output logic resp_undef_o,
    output logic resp_trap_o,
    output logic [5:0] resp_trap_class_o,
    // privilege context
    input wire logic [1:0] cur_el_i,
    input wire logic [1:0] cur_sec_i,
    input wire logic have_el3_i,
    input wire logic have_el2_i,
    input wire logic el2_enabled_i,
    input wire logic sel2_impl_i,
    input wire logic sel2_en_i,
    input wire logic realm_extension_present_i,
    input wire logic fgt_enable_i,
    input wire logic fine_grained_read_trap_i,
    input wire logic [1:0] top_level_buffer_owner_ctrl_i,
    input wire logic top_level_owner_extension_i,
    input wire logic [1:0] level2_buffer_owner_ctrl_i,
    // management events from the write engine
    input wire logic evt_valid_i,
    input wire logic [5:0] evt_class_i,
    input wire logic [15:0] evt_syndrome_i,
    input wire logic evt_async_abort_i,
    input wire logic evt_partial_lost_i,
    input wire logic evt_ext_abort_i,
    input wire logic collision_i,
    // record padding
    input wire logic rec_valid_i,
    input wire logic [LEN_W-1:0] rec_len_i,
    output logic pad_valid_o,
    output logic [LEN_W-1:0] pad_len_o,
    // interrupt
    output logic profiling_buffer_interrupt_o
);
    // --------------------------------------------------------------
    // elaboration checks
    // --------------------------------------------------------------
    initial begin
        if (ALIGN_CODE > pbs_pkg::ALIGN_MAX) begin
            $error("alignment code above 2KB is not defined");
        end
        if (LEN_W < 12) begin
            $error("record length too narrow for 2KB padding");
        end
    end

    // --------------------------------------------------------------
    // decode helpers
    // --------------------------------------------------------------
    // true for an event class this implementation supports
    function automatic logic ec_supported(input logic [5:0] ec,
                                          input logic realm);
        logic ok;
        ok = 1'b0;
        if (ec == pbs_pkg::EC_OTHER || ec == pbs_pkg::EC_S1_ABORT ||
            ec == pbs_pkg::EC_S2_ABORT) begin
            ok = 1'b1;
        end else if (ec == pbs_pkg::EC_GPC ||
                     ec == pbs_pkg::EC_IMPDEF) begin
            ok = realm;
        end
        return ok;
    endfunction

    // true when encoding names the register given by op2
    function automatic logic enc_hit(input logic [15:0] enc,
                                     input logic [2:0] op2);
        return enc == {pbs_pkg::ENC_OP0, pbs_pkg::ENC_OP1,
                       pbs_pkg::ENC_CRN, pbs_pkg::ENC_CRM, op2};
    endfunction

    // --------------------------------------------------------------
    // ownership checker
    // --------------------------------------------------------------
    pbs_ctx_if ctx ();
    assign ctx.el = cur_el_i;
    assign ctx.sec = pbs_pkg::pbs_sec_t'(cur_sec_i);
    assign ctx.have_el3 = have_el3_i;
    assign ctx.have_el2 = have_el2_i;
    assign ctx.sel2_impl = sel2_impl_i;
    assign ctx.sel2_en = sel2_en_i;
    assign ctx.realm_extension_present = realm_extension_present_i;
    assign ctx.top_level_buffer_owner_ctrl = top_level_buffer_owner_ctrl_i;
    assign ctx.top_level_owner_extension = top_level_owner_extension_i;
    assign ctx.level2_buffer_owner_ctrl = level2_buffer_owner_ctrl_i;

    pbs_own_chk u_own_chk (
        .ctx (ctx.chk)
    );

    // --------------------------------------------------------------
    // status register state
    // --------------------------------------------------------------
    logic [5:0] ec_r;
    logic lost_r;
    logic ea_r;
    logic svc_r;
    logic collision_flag_r;
    logic [15:0] mss_r;
    logic [15:0] req_enc;
    logic hit_id;
    logic hit_st;
    logic st_wr;
    logic [63:0] id_val;
    logic [63:0] st_val;

    assign req_enc = {req_op0_i, req_op1_i, req_crn_i, req_crm_i, req_op2_i};
    assign hit_id = enc_hit(req_enc, pbs_pkg::ENC_OP2_ID);
    assign hit_st = enc_hit(req_enc, pbs_pkg::ENC_OP2_STATUS);
    // software writes only outside EL0
    assign st_wr = req_valid_i && req_write_i && hit_st &&
                   cur_el_i != pbs_pkg::EL0;

    // event class: event capture beats software write
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ec_r <= pbs_pkg::EC_RESET;
        end else if (evt_valid_i) begin
            ec_r <= evt_class_i;
        end else if (st_wr) begin
            // reserved code leaves the old, now meaningless value
            if (ec_supported(req_wdata_i[pbs_pkg::ST_EC_LSB +: 6],
                             realm_extension_present_i)) begin
                ec_r <= req_wdata_i[pbs_pkg::ST_EC_LSB +: 6];
            end
        end
    end

    // syndrome word
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mss_r <= pbs_pkg::MSS_RESET;
        end else if (evt_valid_i) begin
            mss_r <= evt_syndrome_i;
        end else if (st_wr) begin
            mss_r <= req_wdata_i[pbs_pkg::ST_MSS_LSB +: 16];
        end
    end

    // record lost flag
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lost_r <= 1'b0;
        end else if (evt_valid_i) begin
            if (evt_async_abort_i) begin
                lost_r <= SETS_ASYNC_LOST;
            end else begin
                lost_r <= evt_partial_lost_i;
            end
        end else if (st_wr) begin
            lost_r <= req_wdata_i[pbs_pkg::ST_LOST_BIT];
        end
    end

    // external abort flag, reads zero when never set
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ea_r <= 1'b0;
        end else if (evt_valid_i) begin
            ea_r <= SETS_EXT_ABORT & evt_ext_abort_i;
        end else if (st_wr) begin
            ea_r <= SETS_EXT_ABORT & req_wdata_i[pbs_pkg::ST_EA_BIT];
        end
    end

    // service flag: set by any event, set wins over clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            svc_r <= 1'b0;
        end else if (evt_valid_i) begin
            svc_r <= 1'b1;
        end else if (st_wr) begin
            svc_r <= req_wdata_i[pbs_pkg::ST_SVC_BIT];
        end
    end

    // collision flag: sticky, set wins over clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            collision_flag_r <= 1'b0;
        end else if (collision_i) begin
            collision_flag_r <= 1'b1;
        end else if (st_wr) begin
            collision_flag_r <= req_wdata_i[pbs_pkg::ST_COLLISION_FLAG_BIT];
        end
    end

    // interrupt follows the service bit
    assign profiling_buffer_interrupt_o = svc_r;

    // --------------------------------------------------------------
    // read values
    // --------------------------------------------------------------
    always_comb begin
        id_val = 64'h0;
        id_val[pbs_pkg::ID_ALIGN_LSB +: 4] = ALIGN_CODE;
        id_val[pbs_pkg::ID_PROHIB_BIT] = ctx.prohibited;
        id_val[pbs_pkg::ID_FLAGUPD_BIT] = FLAG_UPDATES;
    end

    always_comb begin
        st_val = 64'h0;
        st_val[pbs_pkg::ST_EC_LSB +: 6] = ec_r;
        st_val[pbs_pkg::ST_LOST_BIT] = lost_r;
        st_val[pbs_pkg::ST_EA_BIT] = ea_r;
        st_val[pbs_pkg::ST_SVC_BIT] = svc_r;
        st_val[pbs_pkg::ST_COLLISION_FLAG_BIT] = collision_flag_r;
        st_val[pbs_pkg::ST_MSS_LSB +: 16] = mss_r;
    end

    // --------------------------------------------------------------
    // access answer, one cycle after the request
    // --------------------------------------------------------------
    logic resp_valid_r;
    logic [63:0] rdata_r;
    logic undef_r;
    logic trap_r;
    logic [5:0] trap_class_r;
    logic id_trap;

    // fine-grained trap of id reads taken at EL1
    assign id_trap = el2_enabled_i && (have_el3_i || fgt_enable_i) &&
                     fine_grained_read_trap_i;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            resp_valid_r <= 1'b0;
            rdata_r <= 64'h0;
            undef_r <= 1'b0;
            trap_r <= 1'b0;
            trap_class_r <= 6'h00;
        end else begin
            resp_valid_r <= req_valid_i;
            rdata_r <= 64'h0;
            undef_r <= 1'b0;
            trap_r <= 1'b0;
            trap_class_r <= 6'h00;
            if (!req_valid_i) begin
                undef_r <= 1'b0;
            end else if (hit_id) begin
                if (req_write_i || cur_el_i == pbs_pkg::EL0) begin
                    undef_r <= 1'b1;
                end else if (cur_el_i == pbs_pkg::EL1 && id_trap) begin
                    trap_r <= 1'b1;
                    trap_class_r <= pbs_pkg::TRAP_CLASS_SYSREG;
                end else begin
                    rdata_r <= id_val;
                end
            end else if (hit_st) begin
                if (cur_el_i == pbs_pkg::EL0) begin
                    undef_r <= 1'b1;
                end else if (!req_write_i) begin
                    rdata_r <= st_val;
                end
            end else begin
                undef_r <= 1'b1;
            end
        end
    end

    assign resp_valid_o = resp_valid_r;
    assign resp_rdata_o = rdata_r;
    assign resp_undef_o = undef_r;
    assign resp_trap_o = trap_r;
    assign resp_trap_class_o = trap_class_r;

    // --------------------------------------------------------------
    // record padding to the advertised alignment
    // --------------------------------------------------------------
    logic [LEN_W-1:0] pad_mask;
    logic [LEN_W-1:0] pad_sum;
    logic pad_valid_r;
    logic [LEN_W-1:0] pad_len_r;

    assign pad_mask = LEN_W'((1 << ALIGN_CODE) - 1);
    assign pad_sum = LEN_W'(rec_len_i + pad_mask);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pad_valid_r <= 1'b0;
            pad_len_r <= '0;
        end else begin
            pad_valid_r <= rec_valid_i;
            pad_len_r <= pad_sum & ~pad_mask;
        end
    end

    assign pad_valid_o = pad_valid_r;
    assign pad_len_o = pad_len_r;
endmodule
`default_nettype wire

// ---- pbs_tb_placeholder_none.sv ----
// Purpose: intentionally empty compile unit
// Assumes: nothing
// Notes: no content
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ---- pbs_regs_checker.sv ----
// Purpose: port-level assertions for the profiling buffer id/status bank
// Assumes: single clock, synchronous active-high reset
// Notes: bound to pbs_regs; parameters follow the bound instance
`timescale 1ns/100ps
`default_nettype none
module pbs_regs_checker #(
    parameter logic [3:0] ALIGN_CODE = 4'h0,
    parameter int LEN_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // access request and answer
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [3:0] req_crm_i,
    input wire logic [2:0] req_op2_i,
    input wire logic [1:0] cur_el_i,
    input wire logic resp_valid_o,
    input wire logic [63:0] resp_rdata_o,
    input wire logic resp_undef_o,
    input wire logic resp_trap_o,
    input wire logic [5:0] resp_trap_class_o,
    // events and padding
    input wire logic evt_valid_i,
    input wire logic profiling_buffer_interrupt_o,
    input wire logic rec_valid_i,
    input wire logic [LEN_W-1:0] rec_len_i,
    input wire logic pad_valid_o,
    input wire logic [LEN_W-1:0] pad_len_o
);
    localparam logic [LEN_W-1:0] PMASK = (LEN_W'(1) << ALIGN_CODE) - 1'b1;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // ------
    // request decode
    // ------
    wire logic hit = req_valid_i && !req_write_i && req_crm_i == 4'hA;
    wire logic id_rd = hit && req_op2_i == pbs_pkg::ENC_OP2_ID;
    wire logic st_rd = hit && req_op2_i == pbs_pkg::ENC_OP2_STATUS;
    sequence s_id_top;
        id_rd && cur_el_i == pbs_pkg::EL3;
    endsequence
    sequence s_clean_answer;
        resp_valid_o && !resp_undef_o && !resp_trap_o;
    endsequence
    // ------
    // properties
    // ------
    property p_resp_one;
        req_valid_i |=> resp_valid_o;
    endproperty
    property p_no_resp;
        !req_valid_i |=> !resp_valid_o;
    endproperty
    property p_el0_undef;
        req_valid_i && cur_el_i == pbs_pkg::EL0 |=> resp_undef_o && resp_rdata_o == 64'h0;
    endproperty
    property p_trap_class;
        resp_trap_o |-> resp_trap_class_o == pbs_pkg::TRAP_CLASS_SYSREG && !resp_undef_o;
    endproperty
    property p_id_top;
        s_id_top |=> s_clean_answer ##0 resp_rdata_o[4] == 1'b0;
    endproperty
    property p_id_fields;
        id_rd && cur_el_i >= pbs_pkg::EL2 |=> resp_rdata_o[3:0] == ALIGN_CODE && resp_rdata_o[63:6] == 58'h0;
    endproperty
    property p_st_res0;
        st_rd && cur_el_i != pbs_pkg::EL0 |=> resp_rdata_o[63:32] == 32'h0 && resp_rdata_o[25:20] == 6'h0;
    endproperty
    property p_irq_set;
        evt_valid_i |=> profiling_buffer_interrupt_o;
    endproperty
    property p_pad;
        rec_valid_i |=> pad_valid_o && pad_len_o == (($past(rec_len_i) + PMASK) & ~PMASK);
    endproperty
    a_resp_one: assert property (p_resp_one) else $error("no answer to request");
    a_no_resp: assert property (p_no_resp) else $error("answer without request");
    a_el0_undef: assert property (p_el0_undef) else $error("el0 access not undefined");
    a_trap_class: assert property (p_trap_class) else $error("bad trap class");
    a_id_top: assert property (p_id_top) else $error("top level flag not zero");
    a_id_fields: assert property (p_id_fields) else $error("id fields wrong");
    a_st_res0: assert property (p_st_res0) else $error("status reserved bits set");
    a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");
    a_pad: assert property (p_pad) else $error("record padding wrong");
endmodule
bind pbs_regs pbs_regs_checker #(.ALIGN_CODE(ALIGN_CODE), .LEN_W(LEN_W)) u_chk (.clk_i, .srst_i, .req_valid_i,
    .req_write_i, .req_crm_i, .req_op2_i, .cur_el_i, .resp_valid_o, .resp_rdata_o, .resp_undef_o, .resp_trap_o,
    .resp_trap_class_o, .evt_valid_i, .profiling_buffer_interrupt_o, .rec_valid_i, .rec_len_i, .pad_valid_o,
    .pad_len_o);
`default_nettype wire

// ---- pbs_regs_tb.sv ----
// Purpose: self-checking bench for the profiling buffer id/status bank
// Assumes: 50 MHz clock, synchronous reset held six cycles
// Notes: random contexts from an lfsr seeded at E157
`timescale 1ns/100ps
`default_nettype none
module pbs_regs_tb;
    localparam logic [3:0] AC = 4'h3;
    localparam logic [63:0] ST_MASK = 64'h0000_0000_FC0F_FFFF;
    localparam logic [5:0] CODES [5] = '{6'h00, 6'h1E, 6'h1F, 6'h24, 6'h25};
    logic clk_i = 1'b0, srst_i = 1'b1, rv = 1'b0, rw = 1'b0, ev = 1'b0, col = 1'b0, recv = 1'b0;
    logic [2:0] op2 = 3'h0;
    logic [3:0] crm = 4'h0;
    logic [63:0] wd = 64'h0, v, rd;
    logic [1:0] el = 2'h0, sec = 2'h0, tlc = 2'h0, l2c = 2'h0;
    logic h3 = 1'b0, h2 = 1'b0, e2en = 1'b0, s2i = 1'b0, s2e = 1'b0, rep = 1'b0;
    logic fgt = 1'b0, frt = 1'b0, tle = 1'b0, eas = 1'b0, epl = 1'b0, eea = 1'b0, tx;
    logic [5:0] ecl = 6'h0, cls;
    logic [15:0] esy = 16'h0, rlen = 16'h0, padl;
    logic resp_v, und, trp, padv, irq;
    logic [31:0] seed = 32'hE157;
    int n_fail = 0, check_count = 0, cyc = 0;
    // ------
    // clock, timeout and device
    // ------
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            print_verdict();
        end
    end
    pbs_regs #(.ALIGN_CODE(AC)) dut (.clk_i(clk_i), .srst_i(srst_i), .req_valid_i(rv), .req_write_i(rw),
        .req_op0_i(pbs_pkg::ENC_OP0), .req_op1_i(pbs_pkg::ENC_OP1), .req_crn_i(pbs_pkg::ENC_CRN),
        .req_crm_i(crm), .req_op2_i(op2), .req_wdata_i(wd), .resp_valid_o(resp_v), .resp_rdata_o(rd),
        .resp_undef_o(und), .resp_trap_o(trp), .resp_trap_class_o(cls), .cur_el_i(el), .cur_sec_i(sec),
        .have_el3_i(h3), .have_el2_i(h2), .el2_enabled_i(e2en), .sel2_impl_i(s2i), .sel2_en_i(s2e),
        .realm_extension_present_i(rep), .fgt_enable_i(fgt), .fine_grained_read_trap_i(frt),
        .top_level_buffer_owner_ctrl_i(tlc), .top_level_owner_extension_i(tle),
        .level2_buffer_owner_ctrl_i(l2c), .evt_valid_i(ev), .evt_class_i(ecl), .evt_syndrome_i(esy),
        .evt_async_abort_i(eas), .evt_partial_lost_i(epl), .evt_ext_abort_i(eea), .collision_i(col),
        .rec_valid_i(recv), .rec_len_i(rlen), .pad_valid_o(padv), .pad_len_o(padl),
        .profiling_buffer_interrupt_o(irq));
    // ------
    // helpers
    // ------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected prohibited flag from context
    function automatic logic prohib();
        logic own_r, own_ns;
        own_r = rep && tle;
        own_ns = !own_r && tlc[1];
        if (el == 2'h0 || el == 2'h3) return 1'b0;
        if (!h3) return el == 2'h1 && h2 && l2c == 2'h0;
        if (own_r) return sec != 2'h2 || (el == 2'h1 && l2c == 2'h0);
        if (own_ns) return (sec == 2'h0 && (el == 2'h1 || s2i)) || (sec == 2'h2 && rep)
            || (sec == 2'h1 && el == 2'h1 && h2 && l2c == 2'h0);
        return sec == 2'h1 || (sec == 2'h2 && rep) || (sec == 2'h0 && el == 2'h1 && s2i && s2e && l2c == 2'h0);
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one register access, answer sampled after the reply edge
    task automatic acc(input logic w, input logic [2:0] o2, input logic [3:0] cm, input logic [63:0] d);
        @(posedge clk_i);
        {rv, rw, op2, crm, wd} <= {1'b1, w, o2, cm, d};
        @(posedge clk_i);
        rv <= 1'b0;
        #1;
        chk(resp_v, 1'b1);
    endtask
    task automatic rnd_ctx();
        logic [1:0] e, s;
        seed = lfsr(seed);
        e = seed[1:0];
        s = (e == 2'h3) ? 2'h3 : ((seed[3:2] == 2'h3) ? 2'h1 : seed[3:2]);
        @(posedge clk_i);
        {el, sec, h3, e2en, fgt, frt, tle, tlc, l2c, s2e} <= {e, s, seed[12:4], seed[18]};
        h2 <= seed[14] | (e == 2'h2);
        s2i <= seed[16] | (s == 2'h0 && e == 2'h2);
        rep <= seed[17] | (s == 2'h2);
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ------
    // main sequence
    // ------
    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        // id reads across random contexts
        for (int i = 0; i < 60; i++) begin
            rnd_ctx();
            acc(1'b0, pbs_pkg::ENC_OP2_ID, 4'hA, 64'h0);
            tx = el == 2'h1 && e2en && (h3 || fgt) && frt;
            chk(und, el == 2'h0);
            chk(trp, tx);
            chk(cls, {6{tx}} & 6'h18);
            chk(rd, (el == 2'h0 || tx) ? 64'h0 : {58'h0, 1'b0, prohib(), AC});
        end
        // status write and read back per class code
        @(posedge clk_i);
        {el, rep} <= {2'h1, 1'b1};
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            v = {~seed, seed};
            v[31:26] = (i == 5) ? 6'h1F : CODES[i % 5];
            if (i == 5) rep <= 1'b0;
            acc(1'b1, pbs_pkg::ENC_OP2_STATUS, 4'hA, v);
            acc(1'b0, pbs_pkg::ENC_OP2_STATUS, 4'hA, 64'h0);
            if (i == 5) v[31:26] = 6'h25;
            chk(rd, v & ST_MASK);
            chk(irq, v[17]);
        end
        // refused accesses
        acc(1'b1, pbs_pkg::ENC_OP2_ID, 4'hA, 64'h0);
        chk(und, 1'b1);
        acc(1'b0, pbs_pkg::ENC_OP2_ID, 4'hB, 64'h0);
        chk(und, 1'b1);
        // management events and collisions
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, pbs_pkg::ENC_OP2_STATUS, 4'hA, 64'h0);
            chk(irq, 1'b0);
            seed = lfsr(seed);
            @(posedge clk_i);
            {ev, ecl, esy, eas, epl, eea} <= {1'b1, CODES[i % 5], seed[15:0], seed[21:19]};
            @(posedge clk_i);
            ev <= 1'b0;
            col <= i[0];
            @(posedge clk_i);
            col <= 1'b0;
            acc(1'b0, pbs_pkg::ENC_OP2_STATUS, 4'hA, 64'h0);
            chk(rd, {32'h0, ecl, 6'h0, eas | epl, eea, 1'b1, i[0], esy});
        end
        // record padding, zero and aligned lengths first
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            @(posedge clk_i);
            {recv, rlen} <= {1'b1, (i < 2) ? {12'h0, i[0], 3'h0} : {4'h0, seed[11:0]}};
            @(posedge clk_i);
            recv <= 1'b0;
            #1;
            chk(padv, 1'b1);
            chk(padl, (rlen + (16'h1 << AC) - 16'h1) & ~((16'h1 << AC) - 16'h1));
        end
        // el0 access refused
        @(posedge clk_i);
        el <= 2'h0;
        acc(1'b0, pbs_pkg::ENC_OP2_STATUS, 4'hA, 64'h0);
        chk(und, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
